/* shared/tchp_pkg.sv */
package tchp_pkg;
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned ACK_CRIT_NS    = 140000;
  localparam int unsigned ACK_SAVE_NS    = 100000;
  // longest times round down
  localparam logic [11:0] ACK_CRIT_CYC   = 12'(ACK_CRIT_NS / (1000000000 / CLK_HZ));
  localparam logic [11:0] ACK_SAVE_CYC   = 12'(ACK_SAVE_NS / (1000000000 / CLK_HZ));
  localparam int unsigned NVM_WRITE_CYC_DEF = 10000;
  localparam int unsigned BOOT_CYC_DEF   = 5000;
  localparam logic [6:0]  SLAVE_ADDR_DEF = 7'h00;
  localparam logic [7:0]  CMD_PTR        = 8'ha0;
  localparam logic [7:0]  SAVE_CODE      = 8'h01;
  localparam logic [1:0]  SLEEP_512HZ    = 2'h0;
  localparam logic [1:0]  SLEEP_64HZ     = 2'h1;
  localparam logic [1:0]  SLEEP_8HZ      = 2'h2;
  localparam logic [1:0]  SLEEP_1HZ      = 2'h3;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam int unsigned COUNT_W        = 16;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } tchp_byte_t;

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] baseline;
  } tchp_sample_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_WAIT_FALL, ST_STRETCH, ST_ACK, ST_TX, ST_TX_ACK
  } tchp_state_t;
endpackage

/* hdl/tchp_filter.sv */
`timescale 1ns/100ps
module tchp_filter
  import tchp_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               scan_start,
  input  wire logic               raw_valid,
  input  wire logic [COUNT_W-1:0] raw_count,
  input  wire logic               avg_en,
  input  wire logic [1:0]         avg_sel,
  input  wire logic               bus_active,
  output logic                    out_valid,
  output tchp_sample_t            out_sample
);
  logic                 scan_reg;
  logic                 drop_reg;
  logic [COUNT_W+3:0]   acc_reg;
  logic [3:0]           n_reg;
  logic                 base_set_reg;
  wire  [3:0]           n_last   = 4'((5'h2 << avg_sel) - 5'h1);
  wire                  keep     = raw_valid && !drop_reg && !(scan_reg && bus_active);
  wire  [COUNT_W+3:0]   acc_sum  = acc_reg + (COUNT_W+4)'(raw_count);
  // shift count kept three bits wide so sixteen samples do not wrap to zero
  wire  [COUNT_W-1:0]   avg_val  = COUNT_W'(acc_sum >> ({1'b0, avg_sel} + 3'h1));
  wire                  avg_done = keep && avg_en && (n_reg == n_last);
  wire                  emit     = avg_done || (keep && !avg_en);
  wire  [COUNT_W-1:0]   new_val  = avg_en ? avg_val : raw_count;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scan_reg     <= 1'b0;
      drop_reg     <= 1'b0;
      acc_reg      <= '0;
      n_reg        <= 4'h0;
      base_set_reg <= 1'b0;
      out_valid    <= 1'b0;
      out_sample   <= '0;
    end
    else
    begin
      out_valid <= emit;
      if (scan_start)
      begin
        scan_reg <= 1'b1;
        drop_reg <= 1'b0;
      end
      else if (raw_valid)
        scan_reg <= 1'b0;
      if (scan_reg && bus_active && !raw_valid)
        drop_reg <= 1'b1;
      if (keep && avg_en)
      begin
        acc_reg <= avg_done ? '0 : acc_sum;
        n_reg   <= avg_done ? 4'h0 : n_reg + 4'h1;
      end
      else if (!avg_en)
      begin
        acc_reg <= '0;
        n_reg   <= 4'h0;
      end
      if (emit)
      begin
        out_sample.count <= new_val;
        // averaged path freezes baseline at its first value: a touch at power-up sticks
        if (!base_set_reg || !avg_en)
          out_sample.baseline <= new_val;
        base_set_reg <= 1'b1;
      end
    end
  end

  property p_drop;
    @(posedge clock) disable iff (!reset_n)
      (drop_reg && raw_valid && !scan_start) |=> !out_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("dropped sample was emitted");

  property p_avg_hold;
    @(posedge clock) disable iff (!reset_n)
      (avg_en && keep && n_reg != n_last) |=> !out_valid;
  endproperty
  a_avg_hold: assert property (p_avg_hold) else $error("average emitted early");

  property p_stuck;
    @(posedge clock) disable iff (!reset_n)
      (avg_en && base_set_reg && emit) |=> $stable(out_sample.baseline);
  endproperty
  a_stuck: assert property (p_stuck) else $error("baseline moved with averaging on");
endmodule // tchp_filter

/* hdl/tchp_host_port.sv */
`timescale 1ns/100ps
module tchp_host_port
  import tchp_pkg::*;
#(
  parameter int unsigned NVM_WRITE_CYC = NVM_WRITE_CYC_DEF,
  parameter int unsigned BOOT_CYC      = BOOT_CYC_DEF,
  parameter logic [6:0]  SLAVE_ADDR    = SLAVE_ADDR_DEF
)
(
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               scl_i,
  output logic                    scl_o,
  output logic                    scl_oe,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe,
  output tchp_byte_t              rx_byte,
  output logic                    rx_valid,
  output logic                    tx_req,
  input  wire logic [7:0]         tx_data,
  input  wire logic               core_ready,
  input  wire logic [1:0]         sleep_sel,
  output logic                    save_busy,
  output logic                    save_done,
  output logic                    save_fail,
  output logic                    boot_done,
  input  wire logic               scan_start,
  input  wire logic               raw_valid,
  input  wire logic [COUNT_W-1:0] raw_count,
  input  wire logic               avg_en,
  input  wire logic [1:0]         avg_sel,
  output logic                    filt_valid,
  output tchp_sample_t            filt_sample
);
  if (NVM_WRITE_CYC < 1 || BOOT_CYC < 1)
    $error("counts must be at least one cycle");

  function automatic logic agree_next(input logic cur, input logic a, input logic b);
    return (a == b) ? b : cur;
  endfunction

  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  logic        scl_f_reg;
  logic        sda_f_reg;
  tchp_state_t state_reg;
  logic [7:0]  shift_reg;
  logic [2:0]  bit_reg;
  logic        addr_phase_reg;
  logic        read_reg;
  logic        ack_reg;
  logic        first_reg;
  logic [7:0]  ptr_reg;
  logic        save_pend_reg;
  logic [11:0] stc_reg;
  logic [31:0] busy_cnt_reg;
  logic [31:0] boot_cnt_reg;

  wire scl_next  = agree_next(scl_f_reg, scl_sync_reg[1], scl_sync_reg[2]);
  wire sda_next  = agree_next(sda_f_reg, sda_sync_reg[1], sda_sync_reg[2]);
  wire scl_rise  = scl_next && !scl_f_reg;
  wire scl_fall  = !scl_next && scl_f_reg;
  wire start_c   = scl_f_reg && scl_next && sda_f_reg && !sda_next;
  wire stop_c    = scl_f_reg && scl_next && !sda_f_reg && sda_next;
  wire [7:0] rx_full = shift_reg;
  wire addr_hit  = rx_full[7:1] == SLAVE_ADDR;
  // a busy or booting device stays off the bus entirely
  wire addr_ok   = addr_hit && !save_busy && boot_done;
  wire is_save   = !addr_phase_reg && !first_reg && ptr_reg == CMD_PTR
                   && rx_full == SAVE_CODE;
  wire bad_sleep = sleep_sel == SLEEP_512HZ || sleep_sel == SLEEP_64HZ;
  wire [11:0] lim = save_pend_reg ? ACK_SAVE_CYC : ACK_CRIT_CYC;
  wire release_c = addr_phase_reg || save_pend_reg || core_ready
                   || stc_reg == lim - 12'h1;
  wire bus_active = state_reg != ST_IDLE;

  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = state_reg == ST_STRETCH;
  assign sda_oe = (state_reg == ST_ACK && ack_reg) || (state_reg == ST_TX && !shift_reg[7]);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg    <= 1'b1;
      sda_f_reg    <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      scl_f_reg    <= scl_next;
      sda_f_reg    <= sda_next;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      boot_cnt_reg <= '0;
      boot_done    <= 1'b0;
    end
    else if (!boot_done)
    begin
      boot_cnt_reg <= boot_cnt_reg + 32'h1;
      boot_done    <= boot_cnt_reg == BOOT_CYC - 1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg      <= ST_IDLE;
      shift_reg      <= RESET_BYTE;
      bit_reg        <= 3'h0;
      addr_phase_reg <= 1'b0;
      read_reg       <= 1'b0;
      ack_reg        <= 1'b0;
      first_reg      <= 1'b0;
      ptr_reg        <= RESET_BYTE;
      save_pend_reg  <= 1'b0;
      stc_reg        <= 12'h0;
      rx_byte        <= '0;
      rx_valid       <= 1'b0;
      tx_req         <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      tx_req   <= 1'b0;
      if (start_c && boot_done && !save_busy)
      begin
        state_reg      <= ST_RX;
        bit_reg        <= 3'h0;
        addr_phase_reg <= 1'b1;
      end
      else if (stop_c)
        state_reg <= ST_IDLE;
      else
      begin
        case (state_reg)
          ST_RX:
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_next};
              bit_reg   <= bit_reg + 3'h1;
              if (bit_reg == 3'h7)
                state_reg <= ST_WAIT_FALL;
            end
          ST_WAIT_FALL:
            if (scl_fall)
            begin
              state_reg     <= ST_STRETCH;
              stc_reg       <= 12'h0;
              save_pend_reg <= is_save;
              if (!addr_phase_reg)
              begin
                rx_valid <= 1'b1;
                rx_byte  <= '{first: first_reg, data: rx_full};
              end
            end
          ST_STRETCH:
          begin
            stc_reg <= stc_reg + 12'h1;
            if (release_c)
            begin
              state_reg <= ST_ACK;
              ack_reg   <= addr_phase_reg ? addr_ok : 1'b1;
              if (addr_phase_reg)
              begin
                read_reg  <= rx_full[0];
                first_reg <= 1'b1;
              end
              else
              begin
                first_reg <= 1'b0;
                if (first_reg)
                  ptr_reg <= rx_full;
              end
            end
          end
          ST_ACK:
            if (scl_fall)
            begin
              bit_reg        <= 3'h0;
              addr_phase_reg <= 1'b0;
              save_pend_reg  <= 1'b0;
              if (!ack_reg || save_pend_reg)
                state_reg <= ST_IDLE;
              else if (read_reg)
              begin
                state_reg <= ST_TX;
                shift_reg <= tx_data;
                tx_req    <= 1'b1;
              end
              else
                state_reg <= ST_RX;
            end
          ST_TX:
            if (scl_fall)
            begin
              shift_reg <= {shift_reg[6:0], 1'b1};
              bit_reg   <= bit_reg + 3'h1;
              if (bit_reg == 3'h7)
                state_reg <= ST_TX_ACK;
            end
          ST_TX_ACK:
            if (scl_rise && sda_next)
              state_reg <= ST_IDLE;
            else if (scl_fall)
            begin
              state_reg <= ST_TX;
              shift_reg <= tx_data;
              tx_req    <= 1'b1;
              bit_reg   <= 3'h0;
            end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  wire save_go = state_reg == ST_ACK && scl_fall && save_pend_reg && !stop_c && !start_c;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      save_busy    <= 1'b0;
      save_done    <= 1'b0;
      save_fail    <= 1'b0;
      busy_cnt_reg <= '0;
    end
    else
    begin
      save_done <= 1'b0;
      save_fail <= save_go && bad_sleep;
      if (save_go && !bad_sleep)
      begin
        save_busy    <= 1'b1;
        busy_cnt_reg <= '0;
      end
      else if (save_busy)
      begin
        busy_cnt_reg <= busy_cnt_reg + 32'h1;
        if (busy_cnt_reg == NVM_WRITE_CYC - 1)
        begin
          save_busy <= 1'b0;
          save_done <= 1'b1;
        end
      end
    end
  end

  tchp_filter u_filter (
    .clock      (clock),
    .reset_n    (reset_n),
    .scan_start (scan_start),
    .raw_valid  (raw_valid),
    .raw_count  (raw_count),
    .avg_en     (avg_en),
    .avg_sel    (avg_sel),
    .bus_active (bus_active),
    .out_valid  (filt_valid),
    .out_sample (filt_sample)
  );

  property p_ack_crit;
    @(posedge clock) disable iff (!reset_n)
      scl_oe |-> stc_reg < ACK_CRIT_CYC;
  endproperty
  a_ack_crit: assert property (p_ack_crit) else $error("ack latency too long");

  property p_ack_save;
    @(posedge clock) disable iff (!reset_n)
      (scl_oe && save_pend_reg) |-> stc_reg < ACK_SAVE_CYC;
  endproperty
  a_ack_save: assert property (p_ack_save) else $error("save ack too slow");

  sequence s_save_ok;
    save_go && !bad_sleep;
  endsequence
  property p_save_busy;
    @(posedge clock) disable iff (!reset_n)
      s_save_ok |=> save_busy && !save_fail;
  endproperty
  a_save_busy: assert property (p_save_busy) else $error("save did not start");

  property p_save_fail;
    @(posedge clock) disable iff (!reset_n)
      (save_go && bad_sleep) |=> save_fail && !save_busy;
  endproperty
  a_save_fail: assert property (p_save_fail) else $error("bad sleep save not failed");

  property p_busy_quiet;
    @(posedge clock) disable iff (!reset_n)
      (save_busy && state_reg == ST_IDLE) |=> !sda_oe && !scl_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("bus served while saving");

  property p_boot_quiet;
    @(posedge clock) disable iff (!reset_n)
      !boot_done |-> state_reg == ST_IDLE && !sda_oe;
  endproperty
  a_boot_quiet: assert property (p_boot_quiet) else $error("bus touched during boot");
endmodule // tchp_host_port

/* tb/tchp_i2c_host.sv */
`timescale 1ns/100ps
module tchp_i2c_host
(
  input  wire logic clock,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  localparam int HALF = 10;
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic start;
    sda_low <= 1'b1;
    w(HALF);
    scl_low <= 1'b1;
    w(2);
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    w(HALF);
    scl_low <= 1'b0;
    w(HALF);
    sda_low <= 1'b0;
    w(HALF);
  endtask
  // data moves two cycles after scl falls, so no false start or stop is seen
  task automatic xfer(input logic [7:0] b, output logic nack, output int wt);
    for (int i = 7; i >= 0; i--)
    begin
      sda_low <= ~b[i];
      w(HALF);
      scl_low <= 1'b0;
      w(HALF);
      scl_low <= 1'b1;
      w(2);
    end
    sda_low <= 1'b0;
    w(HALF);
    scl_low <= 1'b0;
    wt = 0;
    while (scl !== 1'b1 && wt < 4000)
    begin
      @(posedge clock);
      wt++;
    end
    nack = sda;
    w(HALF);
    scl_low <= 1'b1;
    w(2);
  endtask
  // sampled at the end of the high phase; last byte is answered with a nack
  task automatic rd(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sda_low <= 1'b0;
      w(HALF);
      scl_low <= 1'b0;
      w(HALF);
      b[i] = sda;
      scl_low <= 1'b1;
      w(2);
    end
    sda_low <= !last;
    w(HALF);
    scl_low <= 1'b0;
    w(HALF);
    scl_low <= 1'b1;
    w(2);
  endtask
endmodule // tchp_i2c_host

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import tchp_pkg::*;
  localparam logic [6:0] ADDR = 7'h3c;
  logic clock, reset_n, scan_start, raw_valid, avg_en, core_ready;
  logic scl_o, scl_oe, sda_o, sda_oe, rx_valid, tx_req, save_busy, save_done;
  logic save_fail, boot_done, filt_valid, h_scl_low, h_sda_low;
  logic [COUNT_W-1:0] raw_count;
  logic [1:0]         avg_sel, sleep_sel;
  logic [7:0]         tx_data;
  tchp_byte_t         rx_byte, eb;
  tchp_sample_t       filt_sample, es;
  tchp_byte_t         byte_q[$];
  tchp_sample_t       samp_q[$];
  bit                 base_q[$];
  int                 err_count = 0, checks = 0, done_n = 0, fail_n = 0, t, tx_n = 0;
  wire scl = !(h_scl_low || (scl_oe && !scl_o));
  wire sda = !(h_sda_low || (sda_oe && !sda_o));

  tchp_host_port #(.NVM_WRITE_CYC(400), .BOOT_CYC(10), .SLAVE_ADDR(ADDR)) u_tchp_host_port (
    .clock(clock), .reset_n(reset_n), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .tx_req(tx_req), .tx_data(tx_data), .core_ready(core_ready), .sleep_sel(sleep_sel),
    .save_busy(save_busy), .save_done(save_done), .save_fail(save_fail),
    .boot_done(boot_done), .scan_start(scan_start), .raw_valid(raw_valid),
    .raw_count(raw_count), .avg_en(avg_en), .avg_sel(avg_sel), .filt_valid(filt_valid),
    .filt_sample(filt_sample));
  tchp_i2c_host u_tchp_i2c_host (
    .clock(clock), .scl(scl), .sda(sda), .scl_low(h_scl_low), .sda_low(h_sda_low));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_byte(input tchp_byte_t e, input tchp_byte_t g);
    cmp("rx_byte", 32'(e), 32'(g));
  endtask
  task automatic cmp_samp(input tchp_sample_t e, input tchp_sample_t g, input bit b);
    cmp("filt count", 32'(e.count), 32'(g.count));
    if (b)
      cmp("filt baseline", 32'(e.baseline), 32'(g.baseline));
  endtask
  task automatic final_report;
    cmp("leftover notes", 0, byte_q.size() + samp_q.size());
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic exp_nack, input int lim);
    logic a;
    int   wt;
    u_tchp_i2c_host.xfer(b, a, wt);
    cmp("ack bit", 32'(exp_nack), 32'(a));
    cmp("ack in time", 1, 32'(wt <= lim));
  endtask
  task automatic save(input logic [1:0] sl);
    int d0;
    int f0;
    d0 = done_n;
    f0 = fail_n;
    sleep_sel <= sl;
    u_tchp_i2c_host.start();
    send({ADDR, 1'b0}, 1'b0, ACK_CRIT_CYC);
    byte_q.push_back('{1'b1, CMD_PTR});
    send(CMD_PTR, 1'b0, ACK_CRIT_CYC);
    byte_q.push_back('{1'b0, SAVE_CODE});
    send(SAVE_CODE, 1'b0, ACK_SAVE_CYC);
    u_tchp_i2c_host.stop();
    if (sl >= SLEEP_8HZ)
    begin
      cmp("save_busy", 1, 32'(save_busy));
      u_tchp_i2c_host.start();
      send({ADDR, 1'b0}, 1'b1, ACK_CRIT_CYC);
      u_tchp_i2c_host.stop();
    end
    t = 0;
    while (save_busy !== 1'b0 && t < 2000)
    begin
      @(posedge clock);
      t++;
    end
    if (t >= 2000)
      final_report();
    repeat (4) @(posedge clock);
    cmp("save_done count", 32'(d0 + (sl >= SLEEP_8HZ)), 32'(done_n));
    cmp("save_fail count", 32'(f0 + (sl < SLEEP_8HZ)), 32'(fail_n));
  endtask
  // bus activity between scan start and sample is what the drop filter keys on
  task automatic samp(input logic [15:0] c, input bit busact);
    scan_start <= 1'b1;
    @(posedge clock);
    scan_start <= 1'b0;
    if (busact)
    begin
      u_tchp_i2c_host.start();
      u_tchp_i2c_host.stop();
    end
    repeat (3) @(posedge clock);
    raw_count <= c;
    raw_valid <= 1'b1;
    @(posedge clock);
    raw_valid <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    if (rx_valid === 1'b1)
    begin
      eb = byte_q.size() ? byte_q.pop_front() : 'x;
      cmp_byte(eb, rx_byte);
    end
    if (filt_valid === 1'b1)
    begin
      es = samp_q.size() ? samp_q.pop_front() : 'x;
      cmp_samp(es, filt_sample, base_q.size() ? base_q.pop_front() : 1'b1);
    end
    if (tx_req === 1'b1)
      tx_n++;
    if (save_done === 1'b1)
      done_n++;
    if (save_fail === 1'b1)
      fail_n++;
  end

  initial
  begin
    logic [15:0] c;
    logic [7:0]  rb;
    int          sum;
    int          n;
    {reset_n, scan_start, raw_valid, avg_en, core_ready, avg_sel, sleep_sel} = '0;
    raw_count = '0;
    tx_data = 8'h5a;
    void'($urandom(74763));
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t = 0;
    while (boot_done !== 1'b1 && t < 100)
    begin
      @(posedge clock);
      t++;
    end
    if (t >= 100)
      final_report();
    u_tchp_i2c_host.start();
    send({ADDR, 1'b0}, 1'b0, ACK_CRIT_CYC);
    byte_q.push_back('{1'b1, 8'h10});
    send(8'h10, 1'b0, ACK_CRIT_CYC);
    core_ready <= 1'b1;
    c = 16'($urandom);
    byte_q.push_back('{1'b0, c[7:0]});
    send(c[7:0], 1'b0, 40);
    u_tchp_i2c_host.stop();
    core_ready <= 1'b0;
    tx_data <= 8'($urandom);
    u_tchp_i2c_host.start();
    send({ADDR, 1'b1}, 1'b0, ACK_CRIT_CYC);
    for (int k = 0; k < 2; k++)
    begin
      u_tchp_i2c_host.rd(k == 1, rb);
      cmp("read byte", 32'(tx_data), 32'(rb));
    end
    u_tchp_i2c_host.stop();
    cmp("tx_req count", 2, tx_n);
    u_tchp_i2c_host.start();
    send({ADDR ^ 7'h01, 1'b0}, 1'b1, ACK_CRIT_CYC);
    u_tchp_i2c_host.stop();
    for (int sl = 0; sl < 4; sl++)
      save(2'(sl));
    for (int k = 0; k < 3; k++)
    begin
      c = 16'($urandom);
      if (k != 1)
      begin
        samp_q.push_back('{c, c});
        base_q.push_back(1'b1);
      end
      samp(c, k == 1);
    end
    avg_en <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      avg_sel <= 2'(s);
      n = 2 << s;
      sum = 0;
      for (int k = 0; k < n; k++)
      begin
        c = 16'($urandom % 4096);
        sum += c;
        if (k == n - 1)
        begin
          samp_q.push_back('{16'(sum / n), 16'h0000});
          base_q.push_back(1'b0);
        end
        samp(c, 1'b0);
      end
    end
    repeat (10) @(posedge clock);
    final_report();
  end
endmodule // tb_top
